// *** design/bist_decode.v ***
`timescale 1ns/1ps
`include "bist_defines.vh"
// Combinational decode of the instruction words
module bist_decode (
  // Instruction words
  input  wire [15:0] prefix_word,
  input  wire        prefix_valid,
  input  wire [15:0] first_word,
  input  wire [15:0] second_word,
  // Decoded fields
  output reg         legal,
  output reg  [1:0]  size_code,
  output wire [3:0]  src_sel,
  output wire [3:0]  dst_sel,
  output wire [3:0]  cnt_sel
);

  assign src_sel = first_word[`BIST_SRC_HI:`BIST_SRC_LO];
  assign dst_sel = second_word[`BIST_DST_HI:`BIST_DST_LO];
  assign cnt_sel = second_word[`BIST_CNT_HI:`BIST_CNT_LO];

  wire common_ok;
  assign common_ok = (first_word[3:0] == `BIST_W1_TAIL)
                  && (src_sel != `BIST_FIELD_ZERO)
                  && (second_word[15:12] == `BIST_W2_HEAD)
                  && (dst_sel != `BIST_FIELD_ZERO)
                  && (second_word[3:0] == `BIST_W2_TAIL);

  always @* begin
    legal     = 1'b0;
    size_code = `BIST_SZ_BYTE;
    if (prefix_valid) begin
      // Long form needs the prefix and a set width bit
      legal     = (prefix_word == `BIST_LONG_PREFIX)
               && (first_word[15:8] == `BIST_LONG_W1_HI) && common_ok;
      size_code = `BIST_SZ_LONG;
    end else begin
      legal = (first_word[`BIST_W1_OPC_HI:`BIST_W1_OPC_LO] == `BIST_W1_OPC)
           && common_ok;
      size_code = first_word[`BIST_W1_WIDTH] ? `BIST_SZ_WORD
                                             : `BIST_SZ_BYTE;
    end
  end

endmodule // bist_decode

// *** design/bist_defines.vh ***
`ifndef BIST_DEFINES_VH
`define BIST_DEFINES_VH

// ----------------------------------------
// Instruction encoding
// ----------------------------------------
`define BIST_W1_OPC       7'h1D
`define BIST_W1_OPC_HI    15
`define BIST_W1_OPC_LO    9
`define BIST_W1_WIDTH     8
`define BIST_SRC_HI       7
`define BIST_SRC_LO       4
`define BIST_W1_TAIL      4'h0
`define BIST_W2_HEAD      4'h0
`define BIST_CNT_HI       11
`define BIST_CNT_LO       8
`define BIST_DST_HI       7
`define BIST_DST_LO       4
`define BIST_W2_TAIL      4'h8
`define BIST_LONG_PREFIX  16'h7A02
`define BIST_LONG_W1_HI   8'h3B
`define BIST_FIELD_ZERO   4'h0

// ----------------------------------------
// Element sizes in bytes
// ----------------------------------------
`define BIST_STEP_BYTE    32'h0000_0001
`define BIST_STEP_WORD    32'h0000_0002
`define BIST_STEP_LONG    32'h0000_0004

// ----------------------------------------
// Element size codes
// ----------------------------------------
`define BIST_SZ_BYTE      2'h0
`define BIST_SZ_WORD      2'h1
`define BIST_SZ_LONG      2'h2

`endif

// *** design/bist_step.v ***
`timescale 1ns/1ps
`include "bist_defines.vh"
module bist_step (
  // Clock and reset
  input  wire        sys_clk,
  input  wire        rst,
  // Instruction issue
  input  wire        start,
  input  wire [15:0] prefix_word,
  input  wire        prefix_valid,
  input  wire [15:0] first_word,
  input  wire [15:0] second_word,
  input  wire        system_mode,
  // Register file operands and write-back
  input  wire [31:0] src_value,
  input  wire [31:0] dst_value,
  input  wire [15:0] cnt_value,
  output reg  [3:0]  src_sel_q,
  output reg  [3:0]  dst_sel_q,
  output reg  [3:0]  cnt_sel_q,
  output reg         dst_we_q,
  output reg  [31:0] dst_wdata_q,
  output reg         cnt_we_q,
  output reg  [15:0] cnt_wdata_q,
  // Flag logic
  output reg         ovf_we_q,
  output reg         ovf_q,
  // Port cycle
  output reg         io_req_q,
  output reg  [15:0] io_addr_q,
  output reg  [1:0]  io_size_q,
  input  wire        io_ack,
  input  wire [31:0] io_rdata,
  // Memory cycle
  output reg         mem_req_q,
  output reg  [31:0] mem_addr_q,
  output reg  [1:0]  mem_size_q,
  output reg  [31:0] mem_wdata_q,
  input  wire        mem_ack,
  // Completion
  output reg         done_q,
  output reg         priv_trap_q,
  output reg         illegal_q,
  output reg         busy_q
);

  // ----------------------------------------
  // States
  // ----------------------------------------
  localparam [4:0] ST_IDLE = 5'h01;
  localparam [4:0] ST_IO   = 5'h02;
  localparam [4:0] ST_MEM  = 5'h04;
  localparam [4:0] ST_UPD  = 5'h08;
  localparam [4:0] ST_FIN  = 5'h10;

  reg  [4:0]  state_q;
  reg  [1:0]  size_q;
  reg  [31:0] step_bytes;

  wire        legal;
  wire [1:0]  size_code;
  wire [3:0]  src_sel;
  wire [3:0]  dst_sel;
  wire [3:0]  cnt_sel;
  wire [15:0] cnt_next;

  bist_decode u_decode (
    .prefix_word  (prefix_word),
    .prefix_valid (prefix_valid),
    .first_word   (first_word),
    .second_word  (second_word),
    .legal        (legal),
    .size_code    (size_code),
    .src_sel      (src_sel),
    .dst_sel      (dst_sel),
    .cnt_sel      (cnt_sel)
  );

  always @* begin
    case (size_q)
      `BIST_SZ_WORD: step_bytes = `BIST_STEP_WORD;
      `BIST_SZ_LONG: step_bytes = `BIST_STEP_LONG;
      default:       step_bytes = `BIST_STEP_BYTE;
    endcase
  end

  assign cnt_next = cnt_value - 16'h0001;

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  // Register file read ports follow the latched selects, so operands
  // are assumed valid one cycle after start.
  always @(posedge sys_clk) begin
    if (rst) begin
      state_q     <= ST_IDLE;
      size_q      <= `BIST_SZ_BYTE;
      src_sel_q   <= 4'h0;
      dst_sel_q   <= 4'h0;
      cnt_sel_q   <= 4'h0;
      dst_we_q    <= 1'b0;
      dst_wdata_q <= 32'h0000_0000;
      cnt_we_q    <= 1'b0;
      cnt_wdata_q <= 16'h0000;
      ovf_we_q    <= 1'b0;
      ovf_q       <= 1'b0;
      io_req_q    <= 1'b0;
      io_addr_q   <= 16'h0000;
      io_size_q   <= `BIST_SZ_BYTE;
      mem_req_q   <= 1'b0;
      mem_addr_q  <= 32'h0000_0000;
      mem_size_q  <= `BIST_SZ_BYTE;
      mem_wdata_q <= 32'h0000_0000;
      done_q      <= 1'b0;
      priv_trap_q <= 1'b0;
      illegal_q   <= 1'b0;
      busy_q      <= 1'b0;
    end else begin
      done_q      <= 1'b0;
      priv_trap_q <= 1'b0;
      illegal_q   <= 1'b0;
      dst_we_q    <= 1'b0;
      cnt_we_q    <= 1'b0;
      ovf_we_q    <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (start) begin
            if (!legal) begin
              illegal_q <= 1'b1;
            end else if (!system_mode) begin
              priv_trap_q <= 1'b1;
            end else begin
              src_sel_q <= src_sel;
              dst_sel_q <= dst_sel;
              cnt_sel_q <= cnt_sel;
              size_q    <= size_code;
              busy_q    <= 1'b1;
              state_q   <= ST_IO;
            end
          end
        end
        ST_IO: begin
          if (!io_req_q) begin
            io_req_q  <= 1'b1;
            io_addr_q <= src_value[15:0];
            io_size_q <= size_q;
          end else if (io_ack) begin
            io_req_q    <= 1'b0;
            mem_req_q   <= 1'b1;
            mem_addr_q  <= dst_value;
            mem_size_q  <= size_q;
            mem_wdata_q <= io_rdata;
            state_q     <= ST_MEM;
          end
        end
        ST_MEM: begin
          if (mem_ack) begin
            mem_req_q <= 1'b0;
            state_q   <= ST_UPD;
          end
        end
        ST_UPD: begin
          // Source register has no write port here
          dst_we_q    <= 1'b1;
          dst_wdata_q <= dst_value + step_bytes;
          cnt_we_q    <= 1'b1;
          cnt_wdata_q <= cnt_next;
          ovf_we_q    <= 1'b1;
          ovf_q       <= (cnt_next == 16'h0000);
          state_q     <= ST_FIN;
        end
        ST_FIN: begin
          // Single transfer, never loops back
          done_q  <= 1'b1;
          busy_q  <= 1'b0;
          state_q <= ST_IDLE;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

endmodule // bist_step

// *** testbench/bist_far.sv ***
`timescale 1ns/1ps
// ----
// Port and memory responder, ack after lat wait cycles
// ----
module bist_far (
  // Bus
  input  wire        sys_clk,
  input  wire [3:0]  lat,
  input  wire        io_req_q,
  input  wire        mem_req_q,
  output reg         io_ack = 1'b0,
  output reg         mem_ack = 1'b0,
  output wire [31:0] io_rdata
);
  reg [3:0] w = 4'h0;
  // Idle data inverted so stale reads show
  assign io_rdata = io_ack ? 32'h0000_00B9 : 32'hFFFF_FF46;
  always @(posedge sys_clk) begin
    io_ack <= 1'b0;
    mem_ack <= 1'b0;
    if ((io_req_q && !io_ack) || (mem_req_q && !mem_ack)) begin
      w <= (w == lat) ? 4'h0 : w + 4'h1;
      io_ack <= io_req_q && w == lat;
      mem_ack <= mem_req_q && w == lat;
    end else begin
      // Restart the wait count when no request is pending
      w <= 4'h0;
    end
  end
endmodule // bist_far

// *** testbench/bist_step_assertions.sv ***
`timescale 1ns/1ps
module bist_chk (
  input wire sys_clk, rst, start, busy_q, system_mode, io_req_q, io_ack,
  input wire mem_req_q, mem_ack, dst_we_q, cnt_we_q, ovf_we_q, ovf_q,
  input wire done_q, priv_trap_q, illegal_q,
  input wire [15:0] first_word, io_addr_q, cnt_value, cnt_wdata_q,
  input wire [31:0] src_value, dst_value, io_rdata, mem_wdata_q,
  input wire [31:0] dst_wdata_q,
  input wire [1:0]  mem_size_q
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  port_addr_a: assert property (io_req_q |-> io_addr_q == src_value[15:0])
    else $error("port address wrong");
  io_to_mem_a: assert property (io_req_q && io_ack |=> !io_req_q && mem_req_q
    && mem_wdata_q == $past(io_rdata)) else $error("bad io to mem");
  mem_order_a: assert property ($rose(mem_req_q) |-> $past(io_req_q))
    else $error("memory before port");
  dst_step_a: assert property (dst_we_q |->
    dst_wdata_q == dst_value + (32'h1 << mem_size_q))
    else $error("pointer step wrong");
  cnt_dec_a: assert property (cnt_we_q |-> cnt_wdata_q == cnt_value - 16'h1)
    else $error("counter wrong");
  ovf_flag_a: assert property (ovf_we_q |-> cnt_we_q && ovf_q == (cnt_wdata_q == 16'h0))
    else $error("overflow wrong");
  wb_done_a: assert property (mem_req_q && mem_ack |-> ##2 dst_we_q && cnt_we_q
    ##1 done_q ##1 !io_req_q) else $error("completion wrong");
  priv_trap_a: assert property (start && !busy_q && !system_mode |=>
    priv_trap_q ##1 !io_req_q [*3]) else $error("no trap");
  bad_enc_a: assert property (start && !busy_q && system_mode &&
    first_word[3:0] != 4'h0 |=> illegal_q) else $error("no illegal");
  cover property (done_q && ovf_q);
  cover property (priv_trap_q);
  cover property (illegal_q);
endmodule // bist_chk
bind bist_step bist_chk u_chk (.*);

// *** testbench/testbench.sv ***
`timescale 1ns/1ps
module testbench;
  reg         sys_clk = 1'b0, rst = 1'b1, start = 1'b0, prefix_valid = 1'b0;
  reg         system_mode = 1'b1;
  reg  [15:0] prefix_word = 16'h7A02, first_word = 16'h0, second_word = 16'h0;
  reg  [3:0]  lat = 4'h0;
  reg  [31:0] rf [0:15];
  reg  [39:0] rows [0:3];
  reg  [34:0] bad [0:4];
  wire [3:0]  src_sel_q, dst_sel_q, cnt_sel_q;
  wire        dst_we_q, cnt_we_q, ovf_we_q, ovf_q, io_req_q, mem_req_q, io_ack;
  wire        mem_ack, done_q, priv_trap_q, illegal_q, busy_q;
  wire [1:0]  io_size_q, mem_size_q;
  wire [15:0] io_addr_q, cnt_wdata_q;
  wire [31:0] dst_wdata_q, mem_addr_q, mem_wdata_q, io_rdata;
  wire [31:0] src_value = rf[src_sel_q], dst_value = rf[dst_sel_q];
  wire [15:0] cnt_value = rf[cnt_sel_q][15:0];
  integer     err_count = 0, total_checks = 0, i, n;
  bist_step dut (.*);
  bist_far u_far (.sys_clk, .lat, .io_req_q, .mem_req_q, .io_ack, .mem_ack,
    .io_rdata);
  always #4 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    if (dst_we_q) rf[dst_sel_q] <= dst_wdata_q;
    if (cnt_we_q) rf[cnt_sel_q] <= {rf[cnt_sel_q][31:16], cnt_wdata_q};
  end
  task chk(input [31:0] g, e);
    begin
      total_checks = total_checks + 1;
      if (g !== e) begin
        err_count = err_count + 1;
        $display("mismatch %0t got %h exp %h", $time, g, e);
      end
    end
  endtask
  task test_done;
    begin
      $display("checks %0d errors %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
    end
  endtask
  task issue(input [15:0] f, s, input p, m);
    begin
      first_word = f; second_word = s; prefix_valid = p; system_mode = m;
      start = 1'b1;
      @(negedge sys_clk);
      start = 1'b0;
    end
  endtask
  task run(input [39:0] r);
    reg [31:0] d, a;
    reg [15:0] c;
    begin
      lat = r[39:36];
      d = rf[r[7:4]];
      c = rf[r[11:8]][15:0] - 16'h1;
      a = rf[r[23:20]] & 32'hFFFF;
      issue(r[31:16], r[15:0], r[35], 1'b1);
      for (n = 0; n < 60 && done_q !== 1'b1; n = n + 1) begin
        if (io_req_q) chk(io_addr_q, a);
        if (io_req_q) chk(32'h1 << io_size_q, r[34:32]);
        if (mem_req_q) chk(mem_addr_q, d);
        if (mem_req_q) chk(mem_wdata_q, 32'hB9);
        if (mem_req_q) chk(32'h1 << mem_size_q, r[34:32]);
        if (dst_we_q) chk(dst_wdata_q, d + r[34:32]);
        if (cnt_we_q) chk(cnt_wdata_q, c);
        if (ovf_we_q) chk(ovf_q, c == 16'h0);
        @(negedge sys_clk);
      end
      chk(done_q, 1'b1);
      if (done_q !== 1'b1) test_done;
      @(negedge sys_clk);
      chk(rf[r[23:20]], a | 32'h0001_0000);
    end
  endtask
  initial begin
    for (i = 0; i < 16; i = i + 1) rf[i] = 32'h0001_0AF0 + i;
    rf[3] = 32'h1;
    // Distinct registers only; cnt 1 then 0 covers set and wrap
    rows[0] = 40'h01_3A20_0318;
    rows[1] = 40'h32_3B20_0318;
    rows[2] = 40'h0C_3B20_0318;
    rows[3] = 40'h72_3B50_0678;
    bad[0] = {2'h2, 1'b0, 32'h3B20_0318};
    bad[1] = {2'h1, 1'b1, 32'h3B28_0318};
    bad[2] = {2'h1, 1'b1, 32'h3B00_0318};
    bad[3] = {2'h1, 1'b1, 32'h3B20_0310};
    bad[4] = {2'h1, 1'b1, 32'h3B20_0308};
    repeat (8) @(negedge sys_clk);
    rst = 1'b0;
    for (i = 0; i < 4; i = i + 1) run(rows[i]);
    for (i = 0; i < 5; i = i + 1) begin
      issue(bad[i][31:16], bad[i][15:0], 1'b0, bad[i][32]);
      for (n = 0; n < 4 && !(priv_trap_q | illegal_q); n = n + 1)
        @(negedge sys_clk);
      chk({priv_trap_q, illegal_q}, bad[i][34:33]);
      repeat (3) @(negedge sys_clk);
      chk({io_req_q, mem_req_q, dst_we_q}, 3'h0);
    end
    // Reset in mid-transfer, then a clean instruction again
    issue(rows[1][31:16], rows[1][15:0], 1'b0, 1'b1);
    repeat (2) @(negedge sys_clk);
    rst = 1'b1;
    @(negedge sys_clk);
    rst = 1'b0;
    chk({busy_q, io_req_q, mem_req_q, done_q}, 4'h0);
    run(rows[0]);
    test_done;
  end
endmodule // testbench
